// ### mpp_port_block.sv
// Purpose: General-purpose port pins with direction, pull-ups and edge flags
// Assumes: Classic Wishbone slave, 100 MHz clk_i, synchronous rst_i
// Notes: One wait state on every access; port 11 falling edges interrupt
//
// Contract
// - Port 0 has seven bits; lowest and oscillator-shared bits are input only.
// - Input bits offer a software-enabled on-chip pull-up; here port 0 bit 7 has none.
// - Analog use of port 1 forces its pull-ups off.
// - Ports 8 and 9 pick port or segment in pairs of bits.
// - Port 11 has per-bit direction and flags falling edges on inputs.
// - Ports 2, 3, 7, 10, 11 have per-bit direction; widths 3, 8, 3, 4, 8.
//
// Our own choices: the register addresses and the Wishbone register port.
module mpp_port_block (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [mpp_pkg::ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [mpp_pkg::NPORT*mpp_pkg::PW-1:0] pin_i,
	output logic [mpp_pkg::NPORT*mpp_pkg::PW-1:0] pin_o,
	output logic [mpp_pkg::NPORT*mpp_pkg::PW-1:0] pin_oe_n_o,
	output logic [mpp_pkg::NPORT*mpp_pkg::PW-1:0] pullup_o,
	output logic [15:0] seg_mode_o,
	output logic analog_inputs_o,
	output logic irq_o
);
	import mpp_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [NPORT-1:0][PW-1:0] out;
		logic [NPORT-1:0][PW-1:0] dir;
		logic [NPORT-1:0][PW-1:0] pu;
		logic [PW-1:0] lcd;
		logic adc;
		logic [PW-1:0] sts;
		logic [PW-1:0] msk;
		logic [PW-1:0] p11_prev;
		logic ack;
		logic [31:0] rdat;
	} mpp_state_t;

	mpp_state_t st_q, st_d;

	logic [NPORT-1:0][PW-1:0] rd_val;
	logic [NPORT-1:0][PW-1:0] seg_m;
	logic [PW-1:0] p11_pin;
	logic [PW-1:0] fall;

	// Expand one bit per pair to a full bit mask
	function automatic logic [PW-1:0] pair_mask(input logic [3:0] b);
		logic [PW-1:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[2*i] = b[i];
			m[2*i+1] = b[i];
		end
		return m;
	endfunction

	// Port registers live below the special block
	function automatic logic is_port(input logic [ADR_W-1:0] a);
		return (a[ADR_W-1:8] == '0) && (a[7:4] < 4'(NPORT));
	endfunction

	// ----------------------------------------
	// Port slices
	// ----------------------------------------
	// LCD control picks segments in pairs
	always_comb begin
		seg_m = '0;
		seg_m[SLOT_P8] = pair_mask(st_q.lcd[3:0]);
		seg_m[SLOT_P9] = pair_mask(st_q.lcd[7:4]);
	end

	for (genvar g = 0; g < NPORT; g++) begin : g_port
		mpp_port_slice #(
			.VALID(VALID_M[g]),
			.DIRMSK(DIR_M[g]),
			.PUMSK(PU_M[g])
		) u_slice (
			.out_i(st_q.out[g]),
			.dir_i(st_q.dir[g]),
			.pu_i(st_q.pu[g]),
			.pin_i(pin_i[g*PW +: PW]),
			.seg_i(seg_m[g]),
			.analog_i(g == SLOT_P1 && st_q.adc),
			.drv_o(pin_o[g*PW +: PW]),
			.oe_n_o(pin_oe_n_o[g*PW +: PW]),
			.pu_o(pullup_o[g*PW +: PW]),
			.rd_o(rd_val[g])
		);
	end

	assign seg_mode_o = {seg_m[SLOT_P9], seg_m[SLOT_P8]};
	assign analog_inputs_o = st_q.adc;
	assign p11_pin = pin_i[SLOT_P11*PW +: PW];

	// falling edge on an input bit
	assign fall = st_q.p11_prev & ~p11_pin & ~st_q.dir[SLOT_P11];

	// Level interrupt from unmasked sticky flags
	assign irq_o = |(st_q.sts & st_q.msk);
	assign ack_o = st_q.ack;
	assign dat_o = st_q.rdat;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic req;
		logic wr;
		logic [3:0] slot;
		logic [PW-1:0] wd;
		logic [PW-1:0] clr;
		req = 1'b0;
		wr = 1'b0;
		slot = 4'h0;
		wd = 8'h00;
		clr = 8'h00;
		st_d = st_q;
		req = cyc_i && stb_i;
		// Writes land on the edge the master sees ack
		wr = req && we_i && st_q.ack && sel_i[0];
		slot = adr_i[7:4];
		wd = dat_i[PW-1:0];
		// One wait state, ack drops after one cycle
		st_d.ack = req && !st_q.ack;
		st_d.rdat = '0;
		if (req && !st_q.ack && !we_i) begin
			if (is_port(adr_i)) begin
				case (adr_i[3:2])
					SUB_OUT: st_d.rdat = {24'h0, st_q.out[slot] & VALID_M[slot]};
					SUB_DIR: st_d.rdat = {24'h0, st_q.dir[slot] & DIR_M[slot]};
					SUB_PU: st_d.rdat = {24'h0, st_q.pu[slot] & PU_M[slot]};
					SUB_PIN: st_d.rdat = {24'h0, rd_val[slot]};
					default: st_d.rdat = '0;
				endcase
			end else begin
				case (adr_i)
					LCD_CTRL_ADR: st_d.rdat = {24'h0, st_q.lcd};
					ADC_MODE_ADR: st_d.rdat = {31'h0, st_q.adc};
					IRQ_STS_ADR: st_d.rdat = {24'h0, st_q.sts};
					IRQ_MSK_ADR: st_d.rdat = {24'h0, st_q.msk};
					default: st_d.rdat = '0;
				endcase
			end
		end
		if (wr) begin
			if (is_port(adr_i)) begin
				case (adr_i[3:2])
					SUB_OUT: st_d.out[slot] = wd & VALID_M[slot];
					SUB_DIR: st_d.dir[slot] = wd & DIR_M[slot];
					SUB_PU: st_d.pu[slot] = wd & PU_M[slot];
					default: st_d.rdat = st_d.rdat;
				endcase
			end else begin
				case (adr_i)
					LCD_CTRL_ADR: st_d.lcd = wd;
					ADC_MODE_ADR: st_d.adc = wd[0];
					IRQ_STS_ADR: clr = wd;
					IRQ_MSK_ADR: st_d.msk = wd;
					default: st_d.lcd = st_q.lcd;
				endcase
			end
		end
		// new edges win over a clear
		st_d.sts = (st_q.sts & ~clr) | fall;
		st_d.p11_prev = p11_pin;
		if (rst_i) begin
			st_d = '0;
			for (int p = 0; p < NPORT; p++) begin
				st_d.out[p] = OUT_RST;
				st_d.dir[p] = DIR_RST;
				st_d.pu[p] = PU_RST;
			end
			st_d.lcd = LCD_RST;
			st_d.msk = MSK_RST;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Single register for all state
	always_ff @(posedge clk_i) begin
		st_q <= st_d;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_p0_input_only: assert property (pin_oe_n_o[0] && pin_oe_n_o[7])
		else $error("input-only port 0 bit driven");
	a_pu_inputs: assert property ((pullup_o & ~pin_oe_n_o) == '0)
		else $error("pull-up on a driven bit");
	a_analog_pu: assert property (analog_inputs_o |-> pullup_o[SLOT_P1*PW +: PW] == '0)
		else $error("port 1 pull-up during analog use");
	a_lcd_pairs: assert property (ack_o && we_i && sel_i[0] && adr_i == LCD_CTRL_ADR
		|=> seg_mode_o[1:0] == {2{$past(dat_i[0])}} && seg_mode_o[15:14] == {2{$past(dat_i[7])}})
		else $error("segment pairs not following control write");
	a_fall_flag: assert property (fall[0] |=> st_q.sts[0] && (!st_q.msk[0] || irq_o))
		else $error("falling edge not flagged");
	a_reset_inputs: assert property ($past(rst_i) |-> &pin_oe_n_o && pullup_o == '0)
		else $error("bits not released after reset");
	a_read_port3: assert property (cyc_i && stb_i && !ack_o && !we_i
		&& adr_i == 12'h03c |=> dat_o[7:0] == $past(rd_val[3]))
		else $error("pin read mismatch");

	c_write_dir: cover property (ack_o && we_i && adr_i[3:2] == SUB_DIR);
	c_edge_irq: cover property (fall != '0 ##1 irq_o);
	c_analog: cover property (analog_inputs_o && st_q.pu[SLOT_P1] != '0);

endmodule

// ### mpp_pkg.sv
// Purpose: Constants for the general-purpose port pin block
// Assumes: 32-bit classic Wishbone, byte addresses, 8-bit data in the low lane
// Notes: Ports are held as eight-bit slots; masks trim each port's real width
package mpp_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int NPORT = 9;
	localparam int PW = 8;
	localparam int ADR_W = 12;

	// Slot order: ports 0, 1, 2, 3, 7, 8, 9, 10, 11
	localparam int SLOT_P1 = 1;
	localparam int SLOT_P8 = 5;
	localparam int SLOT_P9 = 6;
	localparam int SLOT_P11 = 8;

	// Bits that exist, slot 8 down to slot 0
	localparam logic [NPORT-1:0][PW-1:0] VALID_M =
		{8'hff, 8'h0f, 8'hff, 8'hff, 8'h07, 8'hff, 8'he0, 8'hff, 8'hbf};
	// Bits whose direction software may choose
	localparam logic [NPORT-1:0][PW-1:0] DIR_M =
		{8'hff, 8'h0f, 8'hff, 8'hff, 8'h07, 8'hff, 8'he0, 8'hff, 8'h3e};
	// Bits that carry an on-chip pull-up
	localparam logic [NPORT-1:0][PW-1:0] PU_M =
		{8'hff, 8'h0f, 8'hff, 8'hff, 8'h07, 8'hff, 8'he0, 8'hff, 8'h3f};

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [ADR_W-1:0] PORT_STRIDE = 12'h010;
	localparam logic [1:0] SUB_OUT = 2'h0;
	localparam logic [1:0] SUB_DIR = 2'h1;
	localparam logic [1:0] SUB_PU = 2'h2;
	localparam logic [1:0] SUB_PIN = 2'h3;
	localparam logic [ADR_W-1:0] LCD_CTRL_ADR = 12'h100;
	localparam logic [ADR_W-1:0] ADC_MODE_ADR = 12'h104;
	localparam logic [ADR_W-1:0] IRQ_STS_ADR = 12'h108;
	localparam logic [ADR_W-1:0] IRQ_MSK_ADR = 12'h10c;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [PW-1:0] OUT_RST = 8'h00;
	localparam logic [PW-1:0] DIR_RST = 8'h00;
	localparam logic [PW-1:0] PU_RST = 8'h00;
	localparam logic [PW-1:0] LCD_RST = 8'h00;
	localparam logic [PW-1:0] MSK_RST = 8'h00;

endpackage

// ### mpp_port_slice.sv
// Purpose: Pin drive, pull-up and read-back of one eight-bit port slot
// Assumes: Pin levels are synchronous to the system clock
// Notes: Purely combinational; all state lives in the top module
module mpp_port_slice #(
	parameter logic [7:0] VALID = 8'hff,
	parameter logic [7:0] DIRMSK = 8'hff,
	parameter logic [7:0] PUMSK = 8'hff
) (
	input wire logic [7:0] out_i,
	input wire logic [7:0] dir_i,
	input wire logic [7:0] pu_i,
	input wire logic [7:0] pin_i,
	input wire logic [7:0] seg_i,
	input wire logic analog_i,
	output logic [7:0] drv_o,
	output logic [7:0] oe_n_o,
	output logic [7:0] pu_o,
	output logic [7:0] rd_o
);

	// ----------------------------------------
	// Pin side
	// ----------------------------------------
	logic [7:0] out_dir;

	assign out_dir = dir_i & DIRMSK & ~seg_i;
	assign drv_o = out_i & out_dir;
	assign oe_n_o = ~out_dir;
	assign pu_o = analog_i ? 8'h00 : (pu_i & PUMSK & ~out_dir & ~seg_i);

	// latch when output, pin when input
	assign rd_o = ((out_dir & out_i) | (~out_dir & pin_i)) & VALID;

endmodule

// ### mpp_pin_board.sv
// Purpose: Board model around the port pins
// Assumes: Bench picks which pins it drives
// Notes: A pin nobody holds reads the inverse of the bench's last offer
module mpp_pin_board (
	input wire logic [71:0] drv_i,
	input wire logic [71:0] oe_n_i,
	input wire logic [71:0] pu_i,
	input wire logic [71:0] ext_i,
	input wire logic [71:0] ext_en_i,
	output logic [71:0] lvl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Wire resolution
	// ----------------------------------------
	// pull-up holds pin
	// Device drive wins, so contention never shows as X
	always_comb begin
		for (int b = 0; b < 72; b++) begin
			if (!oe_n_i[b]) lvl_o[b] = drv_i[b];
			else if (ext_en_i[b]) lvl_o[b] = ext_i[b];
			else if (pu_i[b]) lvl_o[b] = 1'b1;
			else lvl_o[b] = ~ext_i[b];
		end
	end
endmodule

// ### mpp_port_block_tb.sv
// Purpose: Self-checking bench for the port pin block
// Assumes: Wishbone answer comes after one wait state
// Notes: Reset checks first, then row table, then hand-written awkward cases
module mpp_port_block_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mpp_pkg::*;
	typedef struct packed {logic [11:0] adr; logic [7:0] wr; logic [7:0] exp;} mpp_row_t;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, analog_inputs_o;
	logic [11:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, rd;
	logic [71:0] pin_i, pin_o, pin_oe_n_o, pullup_o, ext, ext_en;
	logic [15:0] seg_mode_o;
	int n_fail = 0;
	int checked = 0;
	// Direction masks of ports 0, 2, 3, 7, 10 and 11, then LCD and an unmapped slot
	mpp_row_t rows [8] = '{'{12'h004, 8'hff, 8'h3e}, '{12'h024, 8'hff, 8'he0},
		'{12'h034, 8'hff, 8'hff}, '{12'h044, 8'hff, 8'h07}, '{12'h074, 8'hff, 8'h0f},
		'{12'h084, 8'hff, 8'hff}, '{12'h100, 8'hff, 8'hff}, '{12'h090, 8'hff, 8'h00}};
	// ----------------------------------------
	// Design and board
	// ----------------------------------------
	mpp_port_block dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .pin_i, .pin_o, .pin_oe_n_o, .pullup_o, .seg_mode_o,
		.analog_inputs_o, .irq_o);
	mpp_pin_board brd_u (.drv_i(pin_o), .oe_n_i(pin_oe_n_o), .pu_i(pullup_o), .ext_i(ext),
		.ext_en_i(ext_en), .lvl_o(pin_i));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Classic cycle; ack and read data taken at the rising edge, released just after it
	task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) begin
			n_fail++;
			summarize();
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		summarize();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i} = 3'h0;
		adr_i = 12'h000;
		sel_i = 4'hf;
		dat_i = 32'h00000000;
		ext = '0;
		ext_en = '1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({29'h0, &pin_oe_n_o, |pullup_o, |pin_o}, 32'h4);
		chk({14'h0, seg_mode_o, irq_o, analog_inputs_o}, 32'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			wb(1'b1, rows[i].adr, rows[i].wr);
			wb(1'b0, rows[i].adr, 8'h00);
			chk(rd, {24'h0, rows[i].exp});
		end
		$display("row test done");
		// Port 3 half output, half input
		ext[31:24] <= 8'h3c;
		wb(1'b1, 12'h034, 8'hf0);
		wb(1'b1, 12'h030, 8'ha5);
		wb(1'b0, 12'h03c, 8'h00);
		chk(rd, 32'hac);
		chk({16'h0, pin_oe_n_o[31:24], pin_o[31:24]}, 32'h0fa0);
		$display("read-back test done");
		ext[7:0] <= 8'h81;
		wb(1'b1, 12'h004, 8'hff);
		wb(1'b0, 12'h00c, 8'h00);
		chk(rd, 32'h81);
		chk({30'h0, pin_oe_n_o[7], pin_oe_n_o[0]}, 32'h3);
		$display("input-only test done");
		// Port 1 left to its pull-ups, then analog use
		ext[15:8] <= 8'hff;
		ext_en[15:8] <= 8'h00;
		wb(1'b1, 12'h014, 8'h00);
		wb(1'b1, 12'h018, 8'hff);
		wb(1'b0, 12'h01c, 8'h00);
		chk(rd, 32'hff);
		wb(1'b1, 12'h104, 8'h01);
		wb(1'b0, 12'h01c, 8'h00);
		chk(rd, 32'h00);
		chk({23'h0, analog_inputs_o, pullup_o[15:8]}, 32'h100);
		wb(1'b1, 12'h100, 8'h05);
		@(negedge clk_i);
		chk({16'h0, seg_mode_o}, 32'h0033);
		$display("pull-up and segment test done");
		// Port 11: bit 3 output high, unmask only bit 0
		ext[71:64] <= 8'h0f;
		wb(1'b1, 12'h080, 8'h08);
		wb(1'b1, 12'h084, 8'h08);
		wb(1'b1, 12'h10c, 8'h01);
		ext[64] <= 1'b0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk({31'h0, irq_o}, 32'h1);
		wb(1'b0, 12'h108, 8'h00);
		chk(rd, 32'h01);
		wb(1'b1, 12'h108, 8'h01);
		wb(1'b0, 12'h108, 8'h00);
		chk({rd[30:0], irq_o}, 32'h0);
		// Output bit falling must not flag; masked input bit must not interrupt
		ext[66] <= 1'b0;
		wb(1'b1, 12'h080, 8'h00);
		repeat (3) @(posedge clk_i);
		wb(1'b0, 12'h108, 8'h00);
		chk({rd[30:0], irq_o}, 32'h08);
		// Mask write without the low byte lane is ignored
		sel_i <= 4'he;
		wb(1'b1, 12'h10c, 8'hff);
		sel_i <= 4'hf;
		wb(1'b0, 12'h10c, 8'h00);
		chk(rd, 32'h01);
		$display("edge test done");
		// Pull-ups come back once analog use ends
		wb(1'b1, 12'h104, 8'h00);
		@(negedge clk_i);
		chk({24'h0, pullup_o[15:8]}, 32'hff);
		// Mid-run reset with outputs, pull-ups and segments active
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({29'h0, &pin_oe_n_o, |pullup_o, |pin_o}, 32'h4);
		chk({14'h0, seg_mode_o, irq_o, analog_inputs_o}, 32'h0);
		wb(1'b0, 12'h108, 8'h00);
		chk(rd, 32'h0);
		$display("mid-run reset test done");
		summarize();
	end
endmodule
